// [otp_ctrl.sv]
/*
 holds the per-channel test pattern, format and trim registers of a dual
 converter, and the pattern generators feeding the parallel outputs.
 assumes the serial port has been decoded into a byte write/read strobe
 with an index of the channel; clk is the (divided) sample clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"
// Functional notes
// - per channel four-bit select, zero means normal
// - fixed midscale, positive and negative full-scale
// - checkerboard alternates by bit and word
// - 0101 gives 23-stage pseudo-random sequence
// - 0110 gives 9-stage pseudo-random sequence
// - 0111 toggles whole word ones/zeros
// - 1000 user words, 1001 bit toggle
// - sync, single bit high, mixed frequency
module otp_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_chan,
   input wire logic [`OTP_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   input wire logic [1:0] sample_valid,
   input wire otp_pkg::otp_word_t sample_a,
   input wire otp_pkg::otp_word_t sample_b,
   output otp_pkg::otp_word_t dout_a_r,
   output otp_pkg::otp_word_t dout_b_r,
   output logic [1:0] dout_valid_r,
   input wire logic [1:0] dout_ready,
   output logic [1:0] output_driver_disable_r,
   output logic self_test_engine_start_r,
   output logic [7:0] drive_strength_r
);
   logic [7:0] test_r [2], test_nxt [2];
   logic [7:0] fmt_r [2], fmt_nxt [2];
   logic [7:0] offs_r [2], offs_nxt [2];
   logic [7:0] self_r, self_nxt, drive_nxt;
   otp_pkg::otp_word_t up1_r, up1_nxt, up2_r, up2_nxt;
   logic [7:0] rdata_nxt;
   otp_pkg::otp_word_t skid_out [2];
   logic [1:0] skid_ovalid, skid_iready;
   otp_pkg::otp_word_t dout_nxt [2];
   otp_pkg::otp_word_t dout_q [2];
   logic [1:0] dvalid_nxt;

   // register bank; channel index bit n selects channel n on writes
   always_comb begin
      test_nxt = test_r;
      fmt_nxt = fmt_r;
      offs_nxt = offs_r;
      self_nxt = self_r;
      drive_nxt = drive_strength_r;
      up1_nxt = up1_r;
      up2_nxt = up2_r;
      if (reg_wr) begin
         for (int c = 0; c < 2; c++) begin
            if (reg_chan[c]) begin
               case (reg_addr)
                  `OTP_ADDR_TEST: test_nxt[c] = reg_wdata;
                  `OTP_ADDR_FORMAT: fmt_nxt[c] = reg_wdata;
                  `OTP_ADDR_OFFSET: offs_nxt[c] = reg_wdata;
                  default: ;
               endcase
            end
         end
         case (reg_addr)
            `OTP_ADDR_SELFTEST: self_nxt = reg_wdata;
            `OTP_ADDR_DRIVE: drive_nxt = reg_wdata;
            `OTP_ADDR_UP1_LSB: up1_nxt[7:0] = reg_wdata;
            `OTP_ADDR_UP1_MSB: up1_nxt[15:8] = reg_wdata;
            `OTP_ADDR_UP2_LSB: up2_nxt[7:0] = reg_wdata;
            `OTP_ADDR_UP2_MSB: up2_nxt[15:8] = reg_wdata;
            default: ;
         endcase
      end
      // reads come from the lowest selected channel; unmapped reads zero
      rdata_nxt = reg_rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            `OTP_ADDR_TEST: rdata_nxt = test_r[reg_chan[0] ? 0 : 1];
            `OTP_ADDR_FORMAT: rdata_nxt = fmt_r[reg_chan[0] ? 0 : 1];
            `OTP_ADDR_OFFSET: rdata_nxt = offs_r[reg_chan[0] ? 0 : 1];
            `OTP_ADDR_SELFTEST: rdata_nxt = self_r;
            `OTP_ADDR_DRIVE: rdata_nxt = drive_strength_r;
            `OTP_ADDR_UP1_LSB: rdata_nxt = up1_r[7:0];
            `OTP_ADDR_UP1_MSB: rdata_nxt = up1_r[15:8];
            `OTP_ADDR_UP2_LSB: rdata_nxt = up2_r[7:0];
            `OTP_ADDR_UP2_MSB: rdata_nxt = up2_r[15:8];
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int c = 0; c < 2; c++) begin
            test_r[c] <= `OTP_RST_TEST;
            fmt_r[c] <= `OTP_RST_FORMAT;
            offs_r[c] <= `OTP_RST_OFFSET;
         end
         self_r <= `OTP_RST_SELFTEST;
         drive_strength_r <= `OTP_RST_DRIVE;
         up1_r <= `OTP_RST_UPAT;
         up2_r <= `OTP_RST_UPAT;
         reg_rdata_r <= 8'h00;
      end else begin
         test_r <= test_nxt;
         fmt_r <= fmt_nxt;
         offs_r <= offs_nxt;
         self_r <= self_nxt;
         drive_strength_r <= drive_nxt;
         up1_r <= up1_nxt;
         up2_r <= up2_nxt;
         reg_rdata_r <= rdata_nxt;
      end
   end

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ch
         logic [22:0] lfsr_l_r, lfsr_l_nxt;
         logic [8:0] lfsr_s_r, lfsr_s_nxt;
         logic phase_r, phase_nxt;
         logic usel_r, usel_nxt;
         logic done_r, done_nxt;
         otp_pkg::otp_word_t raw, trimmed, pat, fmtd, word;
         logic adv, in_ok;
         otp_pkg::otp_sel_e sel;

         assign sel = otp_pkg::otp_sel_e'(test_r[ch][`OTP_TEST_SEL_MSB:`OTP_TEST_SEL_LSB]);
         assign raw = (ch == 0) ? sample_a : sample_b;
         assign adv = sample_valid[ch] && skid_iready[ch];

         always_comb begin
            lfsr_l_nxt = lfsr_l_r;
            lfsr_s_nxt = lfsr_s_r;
            phase_nxt = phase_r;
            usel_nxt = usel_r;
            done_nxt = done_r;
            if (adv) begin
               phase_nxt = ~phase_r;
               lfsr_l_nxt = {lfsr_l_r[21:0], lfsr_l_r[22] ^ lfsr_l_r[17]};
               lfsr_s_nxt = {lfsr_s_r[7:0], lfsr_s_r[8] ^ lfsr_s_r[4]};
               if (sel == otp_pkg::OTP_USER) begin
                  if (test_r[ch][`OTP_TEST_USER_LSB]) begin
                     usel_nxt = ~usel_r;
                  end else begin
                     done_nxt = 1'b1;
                  end
               end
            end
            if (test_r[ch][`OTP_TEST_RST_LONG]) begin
               lfsr_l_nxt = `OTP_RST_LONG_SEED;
            end
            if (test_r[ch][`OTP_TEST_RST_SHORT]) begin
               lfsr_s_nxt = `OTP_RST_SHORT_SEED;
            end
            if (sel != otp_pkg::OTP_USER) begin
               usel_nxt = 1'b0;
               done_nxt = 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               lfsr_l_r <= `OTP_RST_LONG_SEED;
               lfsr_s_r <= `OTP_RST_SHORT_SEED;
               phase_r <= 1'b0;
               usel_r <= 1'b0;
               done_r <= 1'b0;
            end else begin
               lfsr_l_r <= lfsr_l_nxt;
               lfsr_s_r <= lfsr_s_nxt;
               phase_r <= phase_nxt;
               usel_r <= usel_nxt;
               done_r <= done_nxt;
            end
         end

         // trim is a signed offset added to the offset-binary sample
         assign trimmed = raw + {{8{offs_r[ch][7]}}, offs_r[ch]};

         always_comb begin
            case (sel)
               otp_pkg::OTP_OFF: pat = trimmed;
               otp_pkg::OTP_MID: pat = `OTP_MIDSCALE;
               otp_pkg::OTP_POSFS: pat = `OTP_POS_FS;
               otp_pkg::OTP_NEGFS: pat = `OTP_NEG_FS;
               otp_pkg::OTP_CHECK: pat = phase_r ? ~`OTP_CHECKER : `OTP_CHECKER;
               otp_pkg::OTP_LONG: pat = lfsr_l_r[15:0];
               otp_pkg::OTP_SHORT: pat = {lfsr_s_r[8:0], lfsr_s_r[8:2]};
               otp_pkg::OTP_WORDTOG: pat = phase_r ? `OTP_NEG_FS : `OTP_POS_FS;
               otp_pkg::OTP_USER: pat = (usel_r && !done_r) ? up2_r : up1_r;
               otp_pkg::OTP_BITTOG: pat = `OTP_TOGGLE;
               otp_pkg::OTP_SYNCP: pat = `OTP_SYNC;
               otp_pkg::OTP_ONEHI: pat = `OTP_ONE_HIGH;
               otp_pkg::OTP_MIXEDP: pat = `OTP_MIXED;
               default: pat = trimmed;
            endcase
         end

         // format coding applies only to conversion data; the invert bit applies to test words too
         always_comb begin
            case (otp_pkg::otp_fmt_e'(fmt_r[ch][`OTP_FMT_MSB:`OTP_FMT_LSB]))
               otp_pkg::OTP_FMT_TC: fmtd = {~trimmed[15], trimmed[14:0]};
               otp_pkg::OTP_FMT_GRAY: fmtd = trimmed ^ (trimmed >> 1);
               default: fmtd = trimmed;
            endcase
            word = (sel == otp_pkg::OTP_OFF) ? fmtd : pat;
            if (fmt_r[ch][`OTP_FMT_INVERT]) begin
               word = ~word;
            end
         end

         assign in_ok = sample_valid[ch];

         otp_skid u_skid (
            .clk(clk),
            .rst(rst),
            .in_valid(in_ok),
            .in_ready(skid_iready[ch]),
            .in_data(word),
            .out_valid(skid_ovalid[ch]),
            .out_ready(!dout_valid_r[ch] || dout_ready[ch]),
            .out_data(skid_out[ch])
         );

         always_comb begin
            dout_nxt[ch] = dout_q[ch];
            dvalid_nxt[ch] = dout_valid_r[ch];
            if (!dout_valid_r[ch] || dout_ready[ch]) begin
               dout_nxt[ch] = skid_out[ch];
               dvalid_nxt[ch] = skid_ovalid[ch];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= '{`OTP_RST_UPAT, `OTP_RST_UPAT};
         dout_valid_r <= 2'h0;
         output_driver_disable_r <= 2'h0;
         self_test_engine_start_r <= 1'b0;
      end else begin
         dout_q <= dout_nxt;
         dout_valid_r <= dvalid_nxt;
         output_driver_disable_r <= {fmt_r[1][`OTP_FMT_DISABLE], fmt_r[0][`OTP_FMT_DISABLE]};
         self_test_engine_start_r <= self_r[`OTP_SELFTEST_EN];
      end
   end

   assign dout_a_r = dout_q[0];
   assign dout_b_r = dout_q[1];
endmodule
`default_nettype wire

// [otp_defines.svh]
/*
 holds register offsets, field positions, reset values and fixed pattern words
 for the per-channel output test pattern and format control block.
 assumes it is included by bare name into the package and the design files.
*/
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH

`define OTP_ADDR_W 8
`define OTP_DATA_W 16
`define OTP_ADDR_TEST 8'h0d
`define OTP_ADDR_SELFTEST 8'h0e
`define OTP_ADDR_OFFSET 8'h10
`define OTP_ADDR_FORMAT 8'h14
`define OTP_ADDR_DRIVE 8'h15
`define OTP_ADDR_UP1_LSB 8'h19
`define OTP_ADDR_UP1_MSB 8'h1a
`define OTP_ADDR_UP2_LSB 8'h1b
`define OTP_ADDR_UP2_MSB 8'h1c
`define OTP_RST_TEST 8'h00
`define OTP_RST_SELFTEST 8'h00
`define OTP_RST_OFFSET 8'h00
`define OTP_RST_FORMAT 8'h00
`define OTP_RST_DRIVE 8'h22
`define OTP_RST_UPAT 16'h0000
`define OTP_RST_LONG_SEED 23'h7fffff
`define OTP_RST_SHORT_SEED 9'h1ff
`define OTP_TEST_SEL_LSB 0
`define OTP_TEST_SEL_MSB 3
`define OTP_TEST_RST_SHORT 4
`define OTP_TEST_RST_LONG 5
`define OTP_TEST_USER_LSB 6
`define OTP_TEST_USER_MSB 7
`define OTP_FMT_LSB 0
`define OTP_FMT_MSB 1
`define OTP_FMT_INVERT 2
`define OTP_FMT_DISABLE 4
`define OTP_SELFTEST_EN 0
`define OTP_MIDSCALE 16'h8000
`define OTP_POS_FS 16'hffff
`define OTP_NEG_FS 16'h0000
`define OTP_CHECKER 16'haaaa
`define OTP_TOGGLE 16'h5555
`define OTP_SYNC 16'h00ff
`define OTP_ONE_HIGH 16'h8000
`define OTP_MIXED 16'ha3a3

`endif

// [otp_pkg.sv]
/*
 holds the types of the output test pattern block.
 assumes otp_defines.svh is on the include path.
*/
`include "otp_defines.svh"
package otp_pkg;
   typedef enum logic [3:0] {
      OTP_OFF = 4'h0, OTP_MID = 4'h1, OTP_POSFS = 4'h2, OTP_NEGFS = 4'h3,
      OTP_CHECK = 4'h4, OTP_LONG = 4'h5, OTP_SHORT = 4'h6, OTP_WORDTOG = 4'h7,
      OTP_USER = 4'h8, OTP_BITTOG = 4'h9, OTP_SYNCP = 4'ha, OTP_ONEHI = 4'hb,
      OTP_MIXEDP = 4'hc
   } otp_sel_e;
   typedef enum logic [1:0] {
      OTP_FMT_OB = 2'h0, OTP_FMT_TC = 2'h1, OTP_FMT_GRAY = 2'h2, OTP_FMT_OB2 = 2'h3
   } otp_fmt_e;
   typedef logic [`OTP_DATA_W-1:0] otp_word_t;
endpackage

// [otp_skid.sv]
/*
 two-entry buffer between the pattern mux and the output register.
 assumes one clock; the drain side may hold ready low for any time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"
module otp_skid (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire otp_pkg::otp_word_t in_data,
   output logic out_valid,
   input wire logic out_ready,
   output otp_pkg::otp_word_t out_data
);
   otp_pkg::otp_word_t mem_r [2];
   otp_pkg::otp_word_t mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      mem_nxt = mem_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
      end
      wr_nxt = push ? ~wr_r : wr_r;
      rd_nxt = pop ? ~rd_r : rd_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_r <= '{`OTP_RST_UPAT, `OTP_RST_UPAT};
         cnt_r <= 2'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
      end
   end
endmodule
`default_nettype wire

// [otp_sink.sv]
/*
 capture logic at the parallel outputs: a ready that can stall at random.
 assumes one clock shared with the block.
*/
`timescale 1ns/1ps
`default_nettype none
module otp_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic stop,
   output logic ready
);
   logic [7:0] lf_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         lf_r <= 8'h5a;
         ready <= 1'b0;
      end else begin
         lf_r <= {lf_r[6:0], lf_r[7] ^ lf_r[5] ^ lf_r[4] ^ lf_r[3]};
         ready <= !stop && (!slow || lf_r[0] || lf_r[2]);
      end
   end
endmodule
`default_nettype wire

// [otp_ctrl_asserts.sv]
/*
 checker on channel a of the pattern block, bound to its ports.
 assumes the same clock and reset as the block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"
module otp_ctrl_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_chan,
   input wire logic [`OTP_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_r,
   input wire otp_pkg::otp_word_t dout_a_r,
   input wire logic [1:0] dout_valid_r,
   input wire logic [1:0] dout_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] tsel_r, tsel_nxt;
   logic inv_r, inv_nxt, hs, wa, ok;
   logic [2:0] cnt_r, cnt_nxt;
   otp_pkg::otp_word_t last_r, last_nxt, fw;
   assign hs = dout_valid_r[0] && dout_ready[0];
   assign wa = reg_wr && reg_chan[0];
   // up to three old words may still be in flight after a mode change; the first five handshakes after it go unchecked
   assign ok = hs && cnt_r >= 3'h5;
   always_comb begin
      tsel_nxt = tsel_r;
      inv_nxt = inv_r;
      cnt_nxt = cnt_r;
      last_nxt = last_r;
      if (hs) begin
         last_nxt = dout_a_r;
         if (cnt_r != 3'h7) cnt_nxt = cnt_r + 3'h1;
      end
      if (wa && reg_addr == `OTP_ADDR_TEST) begin
         tsel_nxt = reg_wdata;
         cnt_nxt = 3'h0;
      end
      if (wa && reg_addr == `OTP_ADDR_FORMAT) begin
         inv_nxt = reg_wdata[2];
         cnt_nxt = 3'h0;
      end
      case (tsel_r[3:0])
         4'h1: fw = `OTP_MIDSCALE;
         4'hb: fw = `OTP_ONE_HIGH;
         4'h2: fw = `OTP_POS_FS;
         4'h3: fw = `OTP_NEG_FS;
         4'h9: fw = `OTP_TOGGLE;
         4'ha: fw = `OTP_SYNC;
         default: fw = `OTP_MIXED;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         tsel_r <= 8'h00;
         inv_r <= 1'b0;
         cnt_r <= 3'h0;
         last_r <= 16'h0000;
      end else begin
         tsel_r <= tsel_nxt;
         inv_r <= inv_nxt;
         cnt_r <= cnt_nxt;
         last_r <= last_nxt;
      end
   end
   a_reset_values: assert property (disable iff (1'b0) rst |=>
      dout_valid_r == 2'b00 && reg_rdata_r == 8'h00) else $error("outputs not cleared by reset");
   a_sel_readback: assert property (reg_rd && !reg_wr && reg_chan[0]
      && reg_addr == `OTP_ADDR_TEST |=> reg_rdata_r == tsel_r) else $error("select readback wrong");
   a_hold_stall: assert property (dout_valid_r[0] && !dout_ready[0] |=>
      dout_valid_r[0] && $stable(dout_a_r)) else $error("word lost under stall");
   a_fixed_words: assert property (ok && tsel_r[3:0] inside {4'h1, 4'h2, 4'h3,
      4'h9, 4'ha, 4'hb, 4'hc} |-> dout_a_r == (fw ^ {16{inv_r}})) else $error("fixed word wrong");
   a_checker_alt: assert property (ok && tsel_r[3:0] == 4'h4 |-> dout_a_r == ~last_r
      && (dout_a_r == `OTP_CHECKER || dout_a_r == `OTP_TOGGLE)) else $error("checkerboard wrong");
   a_long_shift: assert property (ok && tsel_r[3:0] == 4'h5 |->
      dout_a_r[15:1] == last_r[14:0]) else $error("long sequence not shifting");
   a_short_shift: assert property (ok && tsel_r[3:0] == 4'h6 |->
      dout_a_r[15:8] == last_r[14:7]) else $error("short sequence not shifting");
   a_word_toggle: assert property (ok && tsel_r[3:0] == 4'h7 |-> dout_a_r == ~last_r
      && (dout_a_r == 16'hffff || dout_a_r == 16'h0000)) else $error("word toggle wrong");
endmodule
bind otp_ctrl otp_ctrl_asserts u_asserts (.clk, .rst, .reg_wr, .reg_rd, .reg_chan, .reg_addr,
   .reg_wdata, .reg_rdata_r, .dout_a_r, .dout_valid_r, .dout_ready);
`default_nettype wire

// [adc_output_test_pattern_control_tb_top.sv]
/*
 self-checking bench: register access, every pattern code, formats, fill.
 assumes the design files and otp_sink are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module adc_output_test_pattern_control_tb_top;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stop = 0, self_test_engine_start_r;
   logic [1:0] reg_chan = 0, sample_valid = 0, dout_ready, dout_valid_r, output_driver_disable_r;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_r, drive_strength_r;
   logic [15:0] rnd = 16'h005e;
   otp_pkg::otp_word_t sample_a = 0, sample_b = 0, dout_a_r, dout_b_r, up1 = 0, up2 = 0;
   int errors = 0, n_tests = 0;
   int q[2][$];
   logic [3:0] sel[2] = '{4'h0, 4'h0};
   logic [1:0] fmt[2] = '{2'h0, 2'h0};
   logic inv[2] = '{1'b0, 1'b0};
   logic [7:0] offs[2] = '{8'h00, 8'h00};
   logic [7:0] ra[6] = '{8'h0d, 8'h0e, 8'h10, 8'h14, 8'h15, 8'h20};
   logic [7:0] re[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00};
   always #4 clk = ~clk;
   otp_ctrl dut (.clk, .rst, .reg_wr, .reg_rd, .reg_chan, .reg_addr, .reg_wdata, .reg_rdata_r,
      .sample_valid, .sample_a, .sample_b, .dout_a_r, .dout_b_r, .dout_valid_r, .dout_ready,
      .output_driver_disable_r, .self_test_engine_start_r, .drive_strength_r);
   otp_sink sa (.clk, .rst, .slow(1'b1), .stop, .ready(dout_ready[0]));
   otp_sink sb (.clk, .rst, .slow(1'b0), .stop(1'b0), .ready(dout_ready[1]));
   function logic [15:0] nextr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // -1: checked by the bound checker, -2: either user word
   function int expw(input int c, input otp_pkg::otp_word_t s);
      otp_pkg::otp_word_t w;
      // signed trim lands before the format
      s = s + {{8{offs[c][7]}}, offs[c]};
      case (sel[c])
         4'h0: w = (fmt[c] == 2'h1) ? s ^ 16'h8000 : (fmt[c] == 2'h2) ? s ^ (s >> 1) : s;
         4'h1: w = `OTP_MIDSCALE;
         4'hb: w = `OTP_ONE_HIGH;
         4'h2: w = `OTP_POS_FS;
         4'h3: w = `OTP_NEG_FS;
         4'h9: w = `OTP_TOGGLE;
         4'ha: w = `OTP_SYNC;
         4'hc: w = `OTP_MIXED;
         4'h8: return -2;
         default: return -1;
      endcase
      return int'(w ^ {16{inv[c]}});
   endfunction
   always @(posedge clk) if (!rst) for (int c = 0; c < 2; c++)
      if (dout_valid_r[c] && dout_ready[c]) begin
      otp_pkg::otp_word_t g;
      int e;
      g = c ? dout_b_r : dout_a_r;
      `CHK(q[c].size() > 0, 1'b1)
      e = (q[c].size() > 0) ? q[c].pop_front() : -1;
      if (e == -2) `CHK(g === up1 || g === up2, 1'b1)
      else if (e >= 0) `CHK(g, e[15:0])
   end
   task wr(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_wr, reg_chan, reg_addr, reg_wdata} = {1'b1, ch, a, d};
      @(negedge clk);
      reg_wr = 0;
      for (int c = 0; c < 2; c++) if (ch[c] && a == `OTP_ADDR_TEST) sel[c] = d[3:0];
      for (int c = 0; c < 2; c++) if (ch[c] && a == `OTP_ADDR_FORMAT) {inv[c], fmt[c]} = d[2:0];
      for (int c = 0; c < 2; c++) if (ch[c] && a == `OTP_ADDR_OFFSET) offs[c] = d;
      if (a == `OTP_ADDR_UP1_LSB) up1[7:0] = d;
      if (a == `OTP_ADDR_UP1_MSB) up1[15:8] = d;
      if (a == `OTP_ADDR_UP2_LSB) up2[7:0] = d;
      if (a == `OTP_ADDR_UP2_MSB) up2[15:8] = d;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      {reg_rd, reg_chan, reg_addr} = {1'b1, 2'b01, a};
      @(negedge clk);
      reg_rd = 0;
      @(negedge clk);
      `CHK(reg_rdata_r, e)
   endtask
   task stream(input int n);
      int k;
      k = 0;
      for (int i = 0; i < 400 && k < n; i++) begin
         @(negedge clk);
         rnd = nextr(rnd);
         sample_a = rnd;
         rnd = nextr(rnd);
         sample_b = rnd;
         // two outstanding words keep the buffer short of full
         sample_valid = (q[0].size() < 2 && q[1].size() < 2) ? 2'b11 : 2'b00;
         if (sample_valid[0]) q[0].push_back(expw(0, sample_a));
         if (sample_valid[1]) q[1].push_back(expw(1, sample_b));
         if (sample_valid[0]) k++;
      end
      @(negedge clk);
      sample_valid = 0;
      for (int i = 0; i < 300 && q[0].size() + q[1].size() > 0; i++) @(negedge clk);
      `CHK(q[0].size() + q[1].size(), 0)
   endtask
   task final_report;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report;
   end
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 0;
      for (int i = 0; i < 6; i++) rd(ra[i], re[i]);
      `CHK(drive_strength_r, 8'h22)
      wr(2'b01, 8'h20, 8'h77);
      rd(8'h20, 8'h00);
      wr(2'b01, 8'h0e, 8'h01);
      // start pin follows the register one cycle later
      @(negedge clk);
      `CHK(self_test_engine_start_r, 1'b1)
      wr(2'b11, 8'h0e, 8'h00);
      for (int i = 0; i < 4; i++) wr(2'b11, 8'h19 + i[7:0], 8'h12 + 8'h33 * i[7:0]);
      wr(2'b01, 8'h10, 8'hfe);
      for (int f = 0; f < 5; f++) begin
         wr(2'b11, 8'h14, (f == 4) ? 8'h04 : f[7:0]);
         stream(8);
      end
      wr(2'b10, 8'h14, 8'h10);
      @(negedge clk);
      `CHK(output_driver_disable_r, 2'b10)
      wr(2'b11, 8'h14, 8'h00);
      for (int s = 1; s < 13; s++) begin
         wr(2'b01, 8'h0d, 8'h40 | s[7:0]);
         rd(8'h0d, 8'h40 | s[7:0]);
         stream(8);
      end
      wr(2'b10, 8'h0d, 8'h02);
      stream(8);
      wr(2'b11, 8'h0d, 8'h00);
      stop = 1;
      repeat (3) @(negedge clk);
      `CHK(output_driver_disable_r, 2'b00)
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         rnd = nextr(rnd);
         sample_a = rnd;
         sample_valid = 2'b01;
         if (i < 3) q[0].push_back(expw(0, sample_a));
      end
      @(negedge clk);
      sample_valid = 0;
      stop = 0;
      stream(0);
      final_report;
   end
endmodule
`default_nettype wire
